// *** hdl/pwa_regs.sv ***
// counter bytes and shared alias registers of the three pwm instances
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
// Operation
// - each instance has a read/write byte holding offset count bits 7..0
// - timer count bits 15..8 of each instance are readable and writable
// - timer count bits 7..0 of each instance are readable and writable
// - enable alias bits 0,1,2 mirror enable of instances one, two, three
// - load armed alias bits 2..0 mirror load armed of instances three..one
// - output alias bits 2..0 mirror output state of instances three..one
// - alias bits 7..3 read zero and ignore writes
// - implemented alias bits reset to zero on every reset
// - offset low and timer bytes undefined at power-up, kept across resets
// - engine clears load armed after reload; software may clear it too
module pwa_regs
   import pwa_pkg::*;
#(
   parameter int NUM_INST = PWA_NUM_INST
)
(
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire logic                          clk_en,
   input  wire logic [PWA_ADDR_W-1:0]         reg_addr,
   input  wire logic [PWA_DATA_W-1:0]         reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [PWA_DATA_W-1:0]         reg_rdata,
   input  wire logic [NUM_INST-1:0]           tmr_step,
   input  wire logic [NUM_INST-1:0]           tmr_clear,
   input  wire logic [NUM_INST-1:0]           ld_done,
   input  wire logic [NUM_INST-1:0]           out_set,
   input  wire logic [NUM_INST-1:0]           out_clr,
   output logic      [NUM_INST*PWA_DATA_W-1:0] offset_count_low,
   output logic      [NUM_INST*PWA_CNT_W-1:0]  timer_count,
   output logic      [NUM_INST-1:0]           enable,
   output logic      [NUM_INST-1:0]           load_armed,
   output logic      [NUM_INST-1:0]           output_state
);

   localparam int PAD_W = PWA_DATA_W - NUM_INST;
   localparam int MEM_AW = 2;

   logic [PWA_CNT_W-1:0]  tmr_ff     [NUM_INST];
   logic [PWA_CNT_W-1:0]  nxt_tmr_ff [NUM_INST];
   logic [PWA_DATA_W-1:0] rd_ff;
   logic [PWA_DATA_W-1:0] nxt_rd_ff;
   logic                  mem_sel_ff;
   logic                  nxt_mem_sel_ff;
   logic [PWA_DATA_W-1:0] mem_rdata;
   logic [MEM_AW-1:0]     mem_addr;
   logic                  ofl_hit;
   logic [NUM_INST-1:0]   en_sw_wr;
   logic [NUM_INST-1:0]   en_sw_val;
   logic [NUM_INST-1:0]   ld_sw_wr;
   logic [NUM_INST-1:0]   ld_sw_val;
   logic [NUM_INST-1:0]   out_sw_wr;
   logic [NUM_INST-1:0]   out_sw_val;

   // offset low decode; one address per cycle so a single index serves
   always_comb
   begin
      ofl_hit  = 1'b0;
      mem_addr = '0;
      for (int i = 0; i < NUM_INST; i++)
      begin
         if (pwa_hit(reg_addr, A_OFL_BASE, i))
         begin
            ofl_hit  = 1'b1;
            mem_addr = MEM_AW'(i);
         end
      end
   end

   pwa_byte_mem #(
      .DEPTH (NUM_INST),
      .W     (PWA_DATA_W),
      .AW    (MEM_AW)
   ) u_ofl_mem (
      .clk    (clk),
      .clk_en (clk_en),
      .wr     (reg_wr && ofl_hit),
      .waddr  (mem_addr),
      .wdata  (reg_wdata),
      .rd     (reg_rd && ofl_hit),
      .raddr  (mem_addr),
      .rdata  (mem_rdata),
      .flat   (offset_count_low)
   );

   // timer counter: software byte writes override the engine's step
   always_comb
   begin
      for (int i = 0; i < NUM_INST; i++)
      begin
         nxt_tmr_ff[i] = tmr_ff[i];
         if (tmr_clear[i])
            nxt_tmr_ff[i] = TMR_ZERO;
         else if (tmr_step[i])
            nxt_tmr_ff[i] = tmr_ff[i] + TMR_STEP;
         if (reg_wr && pwa_hit(reg_addr, A_TMRH_BASE, i))
            nxt_tmr_ff[i][TMR_HI_MSB:TMR_HI_LSB] = reg_wdata;
         if (reg_wr && pwa_hit(reg_addr, A_TMRL_BASE, i))
            nxt_tmr_ff[i][TMR_LO_MSB:0] = reg_wdata;
      end
   end

   // no reset branch: a warm reset must not disturb a running count
   always_ff @(posedge clk)
   begin
      if (clk_en)
         tmr_ff <= nxt_tmr_ff;
   end

   always_comb
   begin
      for (int i = 0; i < NUM_INST; i++)
         timer_count[i*PWA_CNT_W +: PWA_CNT_W] = tmr_ff[i];
   end

   // alias bit writes from either the home view or the shared alias
   always_comb
   begin
      for (int i = 0; i < NUM_INST; i++)
      begin
         en_sw_wr[i]   = 1'b0;
         en_sw_val[i]  = 1'b0;
         ld_sw_wr[i]   = 1'b0;
         ld_sw_val[i]  = 1'b0;
         out_sw_wr[i]  = 1'b0;
         out_sw_val[i] = 1'b0;
         if (reg_wr && pwa_hit(reg_addr, A_CTL_BASE, i))
         begin
            en_sw_wr[i]   = 1'b1;
            en_sw_val[i]  = reg_wdata[CTL_EN_BIT];
            out_sw_wr[i]  = 1'b1;
            out_sw_val[i] = reg_wdata[CTL_OUT_BIT];
         end
         if (reg_wr && pwa_hit(reg_addr, A_LDC_BASE, i))
         begin
            ld_sw_wr[i]  = 1'b1;
            ld_sw_val[i] = reg_wdata[LDC_ARM_BIT];
         end
         // upper alias bits have no storage, so writes there vanish
         if (reg_wr && reg_addr == A_EN_ALIAS)
         begin
            en_sw_wr[i]  = 1'b1;
            en_sw_val[i] = reg_wdata[i];
         end
         if (reg_wr && reg_addr == A_LD_ALIAS)
         begin
            ld_sw_wr[i]  = 1'b1;
            ld_sw_val[i] = reg_wdata[i];
         end
         if (reg_wr && reg_addr == A_OUT_ALIAS)
         begin
            out_sw_wr[i]  = 1'b1;
            out_sw_val[i] = reg_wdata[i];
         end
      end
   end

   for (genvar g = 0; g < NUM_INST; g++)
   begin : g_alias
      pwa_alias_bit u_en (
         .clk     (clk),
         .sys_rst (sys_rst),
         .clk_en  (clk_en),
         .sw_wr   (en_sw_wr[g]),
         .sw_val  (en_sw_val[g]),
         .hw_set  (1'b0),
         .hw_clr  (1'b0),
         .q       (enable[g])
      );
      pwa_alias_bit u_ld (
         .clk     (clk),
         .sys_rst (sys_rst),
         .clk_en  (clk_en),
         .sw_wr   (ld_sw_wr[g]),
         .sw_val  (ld_sw_val[g]),
         .hw_set  (1'b0),
         .hw_clr  (ld_done[g]),
         .q       (load_armed[g])
      );
      pwa_alias_bit u_out (
         .clk     (clk),
         .sys_rst (sys_rst),
         .clk_en  (clk_en),
         .sw_wr   (out_sw_wr[g]),
         .sw_val  (out_sw_val[g]),
         .hw_set  (out_set[g]),
         .hw_clr  (out_clr[g]),
         .q       (output_state[g])
      );
   end

   // read path; unmapped addresses answer zero
   always_comb
   begin
      nxt_rd_ff      = RD_UNMAPPED;
      nxt_mem_sel_ff = reg_rd && ofl_hit;
      for (int i = 0; i < NUM_INST; i++)
      begin
         if (pwa_hit(reg_addr, A_TMRH_BASE, i))
            nxt_rd_ff = tmr_ff[i][TMR_HI_MSB:TMR_HI_LSB];
         if (pwa_hit(reg_addr, A_TMRL_BASE, i))
            nxt_rd_ff = tmr_ff[i][TMR_LO_MSB:0];
         if (pwa_hit(reg_addr, A_CTL_BASE, i))
         begin
            nxt_rd_ff[CTL_EN_BIT]  = enable[i];
            nxt_rd_ff[CTL_OUT_BIT] = output_state[i];
         end
         if (pwa_hit(reg_addr, A_LDC_BASE, i))
            nxt_rd_ff[LDC_ARM_BIT] = load_armed[i];
      end
      if (reg_addr == A_EN_ALIAS)
         nxt_rd_ff = {{PAD_W{1'b0}}, enable};
      if (reg_addr == A_LD_ALIAS)
         nxt_rd_ff = {{PAD_W{1'b0}}, load_armed};
      if (reg_addr == A_OUT_ALIAS)
         nxt_rd_ff = {{PAD_W{1'b0}}, output_state};
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rd_ff      <= RD_RST;
         mem_sel_ff <= 1'b0;
      end
      else if (clk_en && reg_rd)
      begin
         rd_ff      <= nxt_rd_ff;
         mem_sel_ff <= nxt_mem_sel_ff;
      end
   end

   // both sources are flip-flops; the mux only steers them
   assign reg_rdata = mem_sel_ff ? mem_rdata : rd_ff;

   ofl_roundtrip_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && clk_en && reg_addr == A_OFL_BASE)
      ##1 (reg_rd && clk_en && reg_addr == A_OFL_BASE)
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("offset low byte did not read back");

   tmr_high_wr_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && clk_en && reg_addr == A_TMRH_BASE)
      |=> timer_count[TMR_HI_MSB:TMR_HI_LSB] == $past(reg_wdata))
      else $error("timer high byte write lost");

   tmr_low_wr_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && clk_en && reg_addr == A_TMRL_BASE)
      |=> timer_count[TMR_LO_MSB:0] == $past(reg_wdata))
      else $error("timer low byte write lost");

   en_alias_rd_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && clk_en && reg_addr == A_EN_ALIAS)
      |=> reg_rdata[NUM_INST-1:0] == $past(enable))
      else $error("enable alias shows wrong bits");

   ld_alias_rd_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && clk_en && reg_addr == A_LD_ALIAS)
      |=> reg_rdata[NUM_INST-1:0] == $past(load_armed))
      else $error("load armed alias shows wrong bits");

   out_alias_rd_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && clk_en && reg_addr == A_OUT_ALIAS)
      |=> reg_rdata[NUM_INST-1:0] == $past(output_state))
      else $error("output alias shows wrong bits");

   alias_upper_zero_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && clk_en && reg_addr >= A_EN_ALIAS && reg_addr <= A_OUT_ALIAS)
      |=> reg_rdata[PWA_DATA_W-1:NUM_INST] == '0)
      else $error("unimplemented alias bits not zero");

   alias_reset_a: assert property (
      @(posedge clk)
      $past(sys_rst) |-> (enable == '0 && load_armed == '0 && output_state == '0))
      else $error("alias bits not cleared by reset");

   tmr_keep_rst_a: assert property (
      @(posedge clk)
      (sys_rst && clk_en && tmr_step == '0 && tmr_clear == '0 && !reg_wr)
      |=> $stable(timer_count))
      else $error("timer count disturbed by reset");

   ld_hw_clear_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (clk_en && (ld_done & ~ld_sw_wr) != '0)
      |=> (load_armed & $past(ld_done & ~ld_sw_wr)) == '0)
      else $error("load armed not cleared after reload");

   mirror_share_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && clk_en && reg_addr == A_CTL_BASE)
      ##1 (reg_rd && clk_en && reg_addr == A_EN_ALIAS)
      |=> reg_rdata[0] == $past(reg_wdata[CTL_EN_BIT], 2))
      else $error("home write not visible at alias");

endmodule // pwa_regs

// *** hdl/pwa_pkg.sv ***
// constants for the pwm counter and alias register bank
package pwa_pkg;

   // instance count and data widths
   localparam int PWA_NUM_INST = 3;
   localparam int PWA_ADDR_W   = 8;
   localparam int PWA_DATA_W   = 8;
   localparam int PWA_CNT_W    = 16;

   // register map, one byte address per register
   localparam logic [7:0] A_OFL_BASE  = 8'h00;
   localparam logic [7:0] A_TMRH_BASE = 8'h04;
   localparam logic [7:0] A_TMRL_BASE = 8'h08;
   localparam logic [7:0] A_CTL_BASE  = 8'h0C;
   localparam logic [7:0] A_LDC_BASE  = 8'h10;
   localparam logic [7:0] A_EN_ALIAS  = 8'h14;
   localparam logic [7:0] A_LD_ALIAS  = 8'h15;
   localparam logic [7:0] A_OUT_ALIAS = 8'h16;

   // field positions inside the control and reload trigger views
   localparam int CTL_EN_BIT  = 7;
   localparam int CTL_OUT_BIT = 5;
   localparam int LDC_ARM_BIT = 7;

   // byte lanes of the timer counter
   localparam int TMR_HI_MSB = 15;
   localparam int TMR_HI_LSB = 8;
   localparam int TMR_LO_MSB = 7;

   // reset and default values
   localparam logic                  ALIAS_RST   = 1'b0;
   localparam logic [7:0]            RD_UNMAPPED = 8'h00;
   localparam logic [7:0]            RD_RST      = 8'h00;
   localparam logic [PWA_CNT_W-1:0]  TMR_ZERO    = 16'h0000;
   localparam logic [PWA_CNT_W-1:0]  TMR_STEP    = 16'h0001;

   // address hit on register base plus instance index
   function automatic logic pwa_hit(input logic [7:0] addr,
                                    input logic [7:0] base,
                                    input int         idx);
      return addr == (base + 8'(idx));
   endfunction

endpackage

// *** hdl/pwa_alias_bit.sv ***
// one storage element seen at both its home register and its alias
`timescale 1ns/1ps
module pwa_alias_bit
   import pwa_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic sw_wr,
   input  wire logic sw_val,
   input  wire logic hw_set,
   input  wire logic hw_clr,
   output logic      q
);

   logic bit_ff;
   logic nxt_bit_ff;

   // software wins over the engine: a fresh arming is never lost
   always_comb
   begin
      nxt_bit_ff = bit_ff;
      if (sw_wr)
         nxt_bit_ff = sw_val;
      else if (hw_set)
         nxt_bit_ff = 1'b1;
      else if (hw_clr)
         nxt_bit_ff = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         bit_ff <= ALIAS_RST;
      else if (clk_en)
         bit_ff <= nxt_bit_ff;
   end

   assign q = bit_ff;

endmodule // pwa_alias_bit

// *** hdl/pwa_byte_mem.sv ***
// small byte store with registered read data, no reset on contents
`timescale 1ns/1ps
module pwa_byte_mem
   import pwa_pkg::*;
#(
   parameter int DEPTH = PWA_NUM_INST,
   parameter int W     = PWA_DATA_W,
   parameter int AW    = 2
)
(
   input  wire logic             clk,
   input  wire logic             clk_en,
   input  wire logic             wr,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [W-1:0]     wdata,
   input  wire logic             rd,
   input  wire logic [AW-1:0]    raddr,
   output logic      [W-1:0]     rdata,
   output logic      [DEPTH*W-1:0] flat
);

   logic [W-1:0] mem_ff [DEPTH];
   logic [W-1:0] rdata_ff;

   // contents survive every reset; only power-up leaves them unknown
   always_ff @(posedge clk)
   begin
      if (clk_en && wr)
         mem_ff[waddr] <= wdata;
      if (clk_en && rd)
         rdata_ff <= mem_ff[raddr];
   end

   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
         flat[i*W +: W] = mem_ff[i];
   end

   assign rdata = rdata_ff;

endmodule // pwa_byte_mem

// *** test/tb_top.sv ***
// self-checking bench for the pwm counter and alias register bank
`timescale 1ns/1ps
module tb_top
   import pwa_pkg::*;
;
   logic        clk;
   logic        sys_rst;
   logic        clk_en;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic [2:0]  tmr_step;
   logic [2:0]  tmr_clear;
   logic [2:0]  ld_done;
   logic [2:0]  out_set;
   logic [2:0]  out_clr;
   logic [23:0] offset_count_low;
   logic [47:0] timer_count;
   logic [2:0]  enable;
   logic [2:0]  load_armed;
   logic [2:0]  output_state;
   logic [7:0]  rv;
   int          n_fail;
   int          check_count;
   int          cyc;

   pwa_regs dut_u (
      .clk              (clk),
      .sys_rst          (sys_rst),
      .clk_en           (clk_en),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .tmr_step         (tmr_step),
      .tmr_clear        (tmr_clear),
      .ld_done          (ld_done),
      .out_set          (out_set),
      .out_clr          (out_clr),
      .offset_count_low (offset_count_low),
      .timer_count      (timer_count),
      .enable           (enable),
      .load_armed       (load_armed),
      .output_state     (output_state)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic close_out();
      if (n_fail == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // data load at the edge that takes the strobe and hold until the next read, so sample just past that edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // write then read with no idle cycle between the strobes
   task automatic wr_rd(input logic [7:0] wa, input logic [7:0] wd,
                        input logic [7:0] ra, output logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= wa;
      reg_wdata <= wd;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      reg_addr  <= ra;
      @(posedge clk);
      reg_rd    <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic pulse(input int kind, input logic [2:0] v);
      @(posedge clk);
      case (kind)
         0: tmr_step <= v;
         1: tmr_clear <= v;
         2: ld_done <= v;
         3: out_set <= v;
         default: out_clr <= v;
      endcase
      @(posedge clk);
      tmr_step  <= 3'h0;
      tmr_clear <= 3'h0;
      ld_done   <= 3'h0;
      out_set   <= 3'h0;
      out_clr   <= 3'h0;
      // let the edge's updates settle before the caller looks
      #1;
   endtask

   task automatic t_reset_vals();
      for (int k = 0; k < 3; k++)
      begin
         rd(A_EN_ALIAS + 8'(k), rv);
         chk("alias after reset", 16'h0000, {8'h00, rv});
      end
      chk("alias bits after reset", 16'h0000, {7'h00, enable, load_armed, output_state});
      rd(8'h30, rv);
      chk("unmapped read", 16'h0000, {8'h00, rv});
   endtask

   task automatic t_counters();
      for (int k = 0; k < 3; k++)
      begin
         wr(A_OFL_BASE + 8'(k), 8'hA1 + 8'(k));
         wr(A_TMRH_BASE + 8'(k), 8'h5B + 8'(k));
         wr(A_TMRL_BASE + 8'(k), 8'hC4 + 8'(k));
      end
      for (int k = 0; k < 3; k++)
      begin
         rd(A_OFL_BASE + 8'(k), rv);
         chk("offset low", {8'h00, 8'hA1 + 8'(k)}, {8'h00, rv});
         chk("offset low out", {8'h00, 8'hA1 + 8'(k)}, {8'h00, offset_count_low[8*k +: 8]});
         rd(A_TMRH_BASE + 8'(k), rv);
         chk("timer high", {8'h00, 8'h5B + 8'(k)}, {8'h00, rv});
         rd(A_TMRL_BASE + 8'(k), rv);
         chk("timer low", {8'h00, 8'hC4 + 8'(k)}, {8'h00, rv});
      end
      // carry out of the low byte must reach the high byte
      wr(A_TMRL_BASE + 8'h02, 8'hFF);
      pulse(0, 3'b100);
      chk("timer step carry", 16'h5E00, timer_count[47:32]);
      rd(A_TMRL_BASE + 8'h02, rv);
      chk("timer low after step", 16'h0000, {8'h00, rv});
      pulse(1, 3'b001);
      chk("timer clear", 16'h0000, timer_count[15:0]);
      chk("timer kept", 16'h5CC5, timer_count[31:16]);
      wr_rd(A_OFL_BASE, 8'h3C, A_OFL_BASE, rv);
      chk("offset low back to back", 16'h003C, {8'h00, rv});
   endtask

   task automatic t_enable();
      wr(A_EN_ALIAS, 8'hFD);
      rd(A_EN_ALIAS, rv);
      chk("enable alias", 16'h0005, {8'h00, rv});
      chk("enable bits", 16'h0005, {13'h0000, enable});
      rd(A_CTL_BASE, rv);
      chk("control view 1 enable", 16'h0001, {15'h0000, rv[CTL_EN_BIT]});
      wr(A_CTL_BASE + 8'h01, 8'h80);
      rd(A_EN_ALIAS, rv);
      chk("enable alias via home", 16'h0007, {8'h00, rv});
      // writes with the clock enable low must be ignored
      @(posedge clk);
      clk_en <= 1'b0;
      wr(A_EN_ALIAS, 8'h00);
      clk_en <= 1'b1;
      #1;
      chk("enable frozen", 16'h0007, {13'h0000, enable});
      wr_rd(A_CTL_BASE, 8'h00, A_EN_ALIAS, rv);
      chk("enable alias after home clear", 16'h0006, {8'h00, rv});
   endtask

   task automatic t_load_armed();
      wr(A_LD_ALIAS, 8'h07);
      pulse(2, 3'b010);
      rd(A_LD_ALIAS, rv);
      chk("load armed after reload", 16'h0005, {8'h00, rv});
      wr(A_LDC_BASE, 8'h00);
      rd(A_LD_ALIAS, rv);
      chk("load armed sw clear", 16'h0004, {8'h00, rv});
      rd(A_LDC_BASE + 8'h02, rv);
      chk("reload view 3", 16'h0080, {8'h00, rv});
   endtask

   task automatic t_output();
      pulse(3, 3'b100);
      rd(A_OUT_ALIAS, rv);
      chk("output alias engine", 16'h0004, {8'h00, rv});
      wr(A_CTL_BASE, 8'h20);
      rd(A_OUT_ALIAS, rv);
      chk("output alias via home", 16'h0005, {8'h00, rv});
      wr(A_OUT_ALIAS, 8'hFA);
      #1;
      chk("output bits", 16'h0002, {13'h0000, output_state});
      pulse(4, 3'b010);
      chk("output engine clear", 16'h0000, {13'h0000, output_state});
   endtask

   task automatic t_rerun_reset();
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(A_OFL_BASE + 8'h01, rv);
      chk("offset kept", 16'h00A2, {8'h00, rv});
      rd(A_TMRH_BASE + 8'h01, rv);
      chk("timer kept", 16'h005C, {8'h00, rv});
      chk("alias cleared", 16'h0000, {7'h00, enable, load_armed, output_state});
   endtask

   initial
   begin
      n_fail      = 0;
      check_count = 0;
      cyc         = 0;
      sys_rst     = 1'b1;
      clk_en      = 1'b1;
      reg_addr    = 8'h00;
      reg_wdata   = 8'h00;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      tmr_step    = 3'h0;
      tmr_clear   = 3'h0;
      ld_done     = 3'h0;
      out_set     = 3'h0;
      out_clr     = 3'h0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset_vals();
      t_counters();
      t_enable();
      t_load_armed();
      t_output();
      t_rerun_reset();
      close_out();
   end
endmodule // tb_top
